// >>> shared/adc_host_pkg.sv
package adc_host_pkg;
	// ---------------------------------------------------------------
	// frame layout
	// ---------------------------------------------------------------
	localparam int FRAME_BITS = 16;
	localparam int LEAD_ZEROS = 3;
	localparam int RESULT_BITS = 10;
	localparam int TAIL_ZEROS = 2;
	localparam int TRACK_EDGE = 13;
	localparam int SHUTDOWN_EDGE = 2;
	localparam int KEEP_EDGE = 10;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_SYS_NS = 8;
	localparam int ACQ_MIN_NS = 350;
	localparam int ACQ_MIN_CYC = (ACQ_MIN_NS + CLK_SYS_NS - 1) / CLK_SYS_NS;
	localparam int SCLK_HALF_DEF = 8;
	localparam int QUIET_CYC_DEF = 8;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_LOW = 5'h02,
		ST_HIGH = 5'h04,
		ST_ACQ = 5'h08,
		ST_QUIET = 5'h10
	} state_t;

	typedef struct packed {
		logic [RESULT_BITS-1:0] value;
		logic valid;
		logic dummy;
	} sample_t;
endpackage : adc_host_pkg

// >>> logic/adc_host.sv
`timescale 1ns/10ps
`default_nettype none
module adc_host #(
	parameter int SCLK_HALF = adc_host_pkg::SCLK_HALF_DEF,
	parameter int QUIET_CYC = adc_host_pkg::QUIET_CYC_DEF
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic stop_early,
	input wire logic serial_result_in,
	output logic select_n,
	output logic sclk,
	output logic busy,
	output adc_host_pkg::sample_t sample
);
	// ---------------------------------------------------------------
	// parameter checks
	// ---------------------------------------------------------------
	// data passes two flops, so a half period under three cycles captures the old bit
	if (SCLK_HALF < 3) begin : g_half_short
		$error("adc_host: sclk half period too short");
	end
	if (SCLK_HALF > 256) begin : g_half_long
		$error("adc_host: sclk half period too long");
	end
	if (QUIET_CYC < 1) begin : g_quiet_short
		$error("adc_host: quiet wait too short");
	end
	if (QUIET_CYC > 255) begin : g_quiet_long
		$error("adc_host: quiet wait too long");
	end

	// ---------------------------------------------------------------
	// counter limits
	// ---------------------------------------------------------------
	localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);
	localparam logic [8:0] ACQ_CNT = 9'(adc_host_pkg::ACQ_MIN_CYC);
	localparam logic [8:0] QUIET_CNT = 9'(QUIET_CYC);

	// ---------------------------------------------------------------
	// input synchroniser
	// ---------------------------------------------------------------
	logic data_meta;
	logic data_sync;
	always_ff @(posedge clk_sys) begin
		data_meta <= serial_result_in;
		data_sync <= data_meta;
	end

	// ---------------------------------------------------------------
	// frame sequencer
	// ---------------------------------------------------------------
	adc_host_pkg::state_t state;
	logic [7:0] half_cnt;
	logic [4:0] edge_cnt;
	logic [8:0] wait_cnt;
	logic [15:0] shift;
	logic abort_req;
	logic powered;
	logic half_done;
	assign half_done = (half_cnt == HALF_M1);

	// ---------------------------------------------------------------
	// frame point decoding
	// ---------------------------------------------------------------
	// high half after the last capture has completed
	function automatic logic frame_end(input adc_host_pkg::state_t st, input logic hd, input logic clk_hi,
			input logic [4:0] cnt);
		frame_end = (st == adc_host_pkg::ST_ACQ) && hd && clk_hi && (cnt == 5'(adc_host_pkg::FRAME_BITS));
	endfunction : frame_end

	// an early stop has reached its cut point inside the shutdown window
	function automatic logic cut_point(input adc_host_pkg::state_t st, input logic hd, input logic abort,
			input logic [4:0] cnt);
		cut_point = (st == adc_host_pkg::ST_LOW) && hd && abort
			&& (cnt == 5'(adc_host_pkg::SHUTDOWN_EDGE + 1));
	endfunction : cut_point

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= adc_host_pkg::ST_IDLE;
			select_n <= 1'b1;
			sclk <= 1'b1;
			half_cnt <= 8'h00;
			edge_cnt <= 5'h00;
			wait_cnt <= 9'h000;
			busy <= 1'b0;
			abort_req <= 1'b0;
		end else begin
			case (state)
				adc_host_pkg::ST_IDLE: begin
					half_cnt <= 8'h00;
					if (start) begin
						select_n <= 1'b0;
						busy <= 1'b1;
						edge_cnt <= 5'h00;
						abort_req <= stop_early;
						state <= adc_host_pkg::ST_HIGH;
					end
				end
				adc_host_pkg::ST_HIGH: begin
					half_cnt <= half_done ? 8'h00 : half_cnt + 8'h01;
					if (half_done) begin
						sclk <= 1'b0;
						edge_cnt <= edge_cnt + 5'h01;
						state <= adc_host_pkg::ST_LOW;
					end
				end
				adc_host_pkg::ST_LOW: begin
					half_cnt <= half_done ? 8'h00 : half_cnt + 8'h01;
					if (half_done) begin
						sclk <= 1'b1;
						if (cut_point(state, half_done, abort_req, edge_cnt)) begin
							select_n <= 1'b1;
							wait_cnt <= QUIET_CNT;
							state <= adc_host_pkg::ST_QUIET;
						end else if (edge_cnt == 5'(adc_host_pkg::TRACK_EDGE)) begin
							wait_cnt <= ACQ_CNT;
							state <= adc_host_pkg::ST_ACQ;
						end else begin
							state <= adc_host_pkg::ST_HIGH;
						end
					end
				end
				adc_host_pkg::ST_ACQ: begin
					// clock keeps running for bits 14..16, then select rises
					half_cnt <= half_done ? 8'h00 : half_cnt + 8'h01;
					if (wait_cnt != 9'h000) begin
						wait_cnt <= wait_cnt - 9'h001;
					end
					if (half_done) begin
						if (sclk) begin
							if (edge_cnt == 5'(adc_host_pkg::FRAME_BITS)) begin
								select_n <= 1'b1;
								wait_cnt <= (wait_cnt > QUIET_CNT) ? wait_cnt : QUIET_CNT;
								state <= adc_host_pkg::ST_QUIET;
							end else if (wait_cnt == 9'h000 || edge_cnt != 5'(adc_host_pkg::TRACK_EDGE)) begin
								sclk <= 1'b0;
								edge_cnt <= edge_cnt + 5'h01;
							end
						end else begin
							sclk <= 1'b1;
						end
					end
				end
				adc_host_pkg::ST_QUIET: begin
					if (wait_cnt != 9'h000) begin
						wait_cnt <= wait_cnt - 9'h001;
					end else begin
						busy <= 1'b0;
						state <= adc_host_pkg::ST_IDLE;
					end
				end
				default: state <= adc_host_pkg::ST_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// receive shifter, sampled on rising clock
	// ---------------------------------------------------------------
	logic rise_tick;
	assign rise_tick = half_done && !sclk && (state == adc_host_pkg::ST_LOW || state == adc_host_pkg::ST_ACQ);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			shift <= 16'h0000;
		end else if (state == adc_host_pkg::ST_IDLE && start) begin
			shift <= 16'h0000;
		end else if (rise_tick) begin
			shift <= {shift[14:0], data_sync};
		end
	end

	// ---------------------------------------------------------------
	// result and power tracking
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			sample <= '0;
			powered <= 1'b0;
		end else begin
			sample.valid <= 1'b0;
			if (frame_end(state, half_done, sclk, edge_cnt)) begin
				// bits 12..3 of the frame hold the msb-first code, bit 0 is the floating 16th
				sample.value <= shift[adc_host_pkg::RESULT_BITS + adc_host_pkg::TAIL_ZEROS:adc_host_pkg::TAIL_ZEROS + 1];
				sample.valid <= 1'b1;
				sample.dummy <= !powered;
				powered <= 1'b1;
			end else if (cut_point(state, half_done, abort_req, edge_cnt)) begin
				powered <= 1'b0;
			end
		end
	end
endmodule : adc_host
`default_nettype wire

// >>> bench/adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_model (
	input wire logic select_n,
	input wire logic sclk,
	input wire logic [9:0] code,
	output logic data
);
	logic [15:0] frame;
	int falls = 0;
	logic live = 1'b0;
	logic awake = 1'b0;
	initial data = 1'b0;
	always @(negedge select_n) begin
		falls = 0;
		live = 1'b1;
		frame = {4'h0, awake ? code : ~code, 2'h0};
		awake = 1'b1;
		data = frame[15];
	end
	always @(negedge sclk) if (live) begin
		falls = falls + 1;
		if (falls == 16) begin
			live = 1'b0;
			data = ~data;
		end else data = frame[15 - falls];
	end
	always @(posedge select_n) begin
		if (falls >= 2 && falls < 10) awake = 1'b0;
		if (live) data = ~data;
		live = 1'b0;
	end
endmodule : adc_model
`default_nettype wire

// >>> bench/adc_host_properties.sv
`timescale 1ns/10ps
`default_nettype none
module adc_host_properties (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic select_n,
	input wire logic sclk,
	input wire logic busy,
	input wire adc_host_pkg::sample_t sample
);
	logic [4:0] n;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// counts sclk rises inside a frame
	always_ff @(posedge clk_sys) begin
		if (!rst_n || select_n) n <= 5'h0;
		else if ($rose(sclk)) n <= n + 5'h1;
	end
	a_start_frame: assert property (start && !busy && select_n |=> !select_n && busy) else $error("no frame");
	a_acq_gap: assert property ($fell(sclk) && n == 5'hd |-> $past(n, 43) == 5'hd) else $error("short gap");
	a_frame_len: assert property ($rose(select_n) |-> n inside {[5'h2:5'h9], 5'h10}) else $error("bad len");
	a_quiet_gap: assert property ($rose(select_n) |-> select_n [*8]) else $error("no quiet");
	a_sclk_idle: assert property (select_n |-> sclk) else $error("sclk idle");
	a_sclk_low: assert property ($fell(sclk) |-> !sclk [*8]) else $error("sclk low");
	a_valid_pulse: assert property (sample.valid |=> !sample.valid) else $error("long valid");
	a_valid_end: assert property (sample.valid |-> select_n && busy && n == 5'h10) else $error("early valid");
endmodule : adc_host_properties
bind adc_host adc_host_properties chk (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .select_n(select_n),
	.sclk(sclk), .busy(busy), .sample(sample));
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic clk_sys, rst_n, start, stop_early, data, select_n, sclk, busy;
	logic [9:0] code;
	adc_host_pkg::sample_t smp;
	int miscompares = 0;
	int n_tests = 0;
	adc_host dut (.clk_sys(clk_sys), .rst_n(rst_n), .start(start), .stop_early(stop_early),
		.serial_result_in(data), .select_n(select_n), .sclk(sclk), .busy(busy), .sample(smp));
	adc_model dev (.select_n(select_n), .sclk(sclk), .code(code), .data(data));
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic end_sim;
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_sim
	// one frame; checks count of results, dummy flag and code
	task automatic conv(input logic [9:0] c, input logic dm, input logic early);
		int t;
		logic [1:0] nv;
		adc_host_pkg::sample_t got;
		nv = 2'h0;
		got = '0;
		code = c;
		start = 1'b1;
		stop_early = early;
		@(negedge clk_sys);
		start = 1'b0;
		stop_early = 1'b0;
		for (t = 0; t < 2000 && busy !== 1'b0; t++) begin
			@(negedge clk_sys);
			if (smp.valid === 1'b1) begin
				nv = nv + 2'h1;
				got = smp;
			end
		end
		if (t == 2000) miscompares++;
		n_tests++;
		if ({nv, got.dummy, got.value} !== (early ? 13'h0 : {2'h1, dm, dm ? ~c : c})) begin
			miscompares++;
			$display("wrong value at %0t: %h expected %h", $time, {nv, got.dummy, got.value},
				early ? 13'h0 : {2'h1, dm, dm ? ~c : c});
		end
	endtask : conv
	task automatic s_powerup;
		conv(10'h155, 1'b1, 1'b0);
	endtask : s_powerup
	task automatic s_codes;
		conv(10'h2a5, 1'b0, 1'b0);
		conv(10'h3ff, 1'b0, 1'b0);
		conv(10'h000, 1'b0, 1'b0);
		conv(10'h001, 1'b0, 1'b0);
	endtask : s_codes
	task automatic s_shutdown;
		conv(10'h0f0, 1'b0, 1'b1);
		conv(10'h30c, 1'b1, 1'b0);
		conv(10'h30c, 1'b0, 1'b0);
	endtask : s_shutdown
	initial begin
		rst_n = 1'b0;
		start = 1'b0;
		stop_early = 1'b0;
		code = 10'h0;
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		s_powerup();
		s_codes();
		s_shutdown();
		end_sim();
	end
	initial begin
		#160000;
		miscompares++;
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
